// >>> core/ecis_defs.vh
// constants for the encoder and command input splitter block
// assumes a 20 MHz device clock and one power-up reset
// ======================================================================
// Notes on behaviour
// - mode routes inputs to encoders or commands
// - dual mode: quadrature pairs 1/2 and 3/4
// - single channel counts A; B gives direction
// - inverse pairs must be complementary, else error
// - homogeneous pairs must match, else error
// - single-input mode: four commands, no check
// - mixed: pair one checked, three and four single
// - single-analog variant allows four command inputs
// - modes 0,1,2,6 forward analog input, ~200 ns
// - any error shifts analog repeat offset
// - square repeat follows sensor one or two
// - square repeat always square, 1:1 periods
// - input to square repeat delay about 600 ns; the squared analog source takes 8 cycles, about 400 ns
// - error stops pulses, drivers high impedance
// - converted analog source error also errors output
// - current setpoint scales start..end to 4..20 mA
// - any error commands 0 mA
// - open current loop enters error state
`ifndef ECIS_DEFS_VH
`define ECIS_DEFS_VH

// input function codes
`define ECIS_FN_QUAD 3'h0
`define ECIS_FN_SINGLE 3'h1
`define ECIS_FN_INVERSE 3'h2
`define ECIS_FN_HOMOG 3'h3
`define ECIS_FN_FOUR 3'h4
`define ECIS_FN_MIXED 3'h5

// operating modes that forward the analog encoder
`define ECIS_OPMODE_0 4'h0
`define ECIS_OPMODE_1 4'h1
`define ECIS_OPMODE_2 4'h2
`define ECIS_OPMODE_6 4'h6

// timing
`define ECIS_CLK_MHZ 20
`define ECIS_SQ_DELAY_NS 600
`define ECIS_SQ_DELAY_CYC ((`ECIS_SQ_DELAY_NS * `ECIS_CLK_MHZ) / 1000)
// edges spent in sync, filter, line entry and output stage
`define ECIS_SQ_FRONT_CYC 7
`define ECIS_FILT_LEN 3

// current setpoint codes: 0 mA, 4 mA, 16 mA span (0.01 mA units)
`define ECIS_MA_ZERO 16'h0000
`define ECIS_MA_FOUR 16'h0190
`define ECIS_MA_SPAN 16'h0640

`endif

// >>> core/ecis_splitter.v
// encoder and command input splitter: HTL inputs, pair checks, repeaters
// assumes pins are asynchronous; frequency values come from logic on clock
`timescale 1ns/1ps
`include "ecis_defs.vh"

module ecis_splitter (
    // clock and reset
    input wire i_clock,
    input wire i_reset_n,
    input wire i_clock_enable,
    // configuration
    input wire [2:0] i_input_function,
    input wire [3:0] i_operating_mode,
    input wire i_mixed_pair_inverse,
    input wire i_repeat_select_sensor_two,
    input wire i_repeat_source_analog,
    input wire i_analog_select_sensor_two,
    input wire [7:0] i_mismatch_tolerance,
    input wire [15:0] i_analog_start_freq,
    input wire [15:0] i_analog_end_freq,
    input wire i_clear_error,
    // HTL pins
    input wire i_command_input_one,
    input wire i_command_input_one_partner,
    input wire i_command_input_two,
    input wire i_command_input_two_partner,
    // analog encoder signals (already squared) and status
    input wire i_first_analog_encoder_a,
    input wire i_first_analog_encoder_b,
    input wire i_analog_encoder_error,
    input wire i_external_error,
    // measured frequencies and current loop sense
    input wire [15:0] i_sensor_one_freq,
    input wire [15:0] i_sensor_two_freq,
    input wire i_current_loop_open,
    // decoded commands and counts
    output reg [3:0] o_commands,
    output reg [15:0] o_sensor_one_count,
    output reg [15:0] o_sensor_two_count,
    output reg o_sensor_one_dir,
    output reg o_sensor_two_dir,
    // analog encoder repeat output controls
    output reg o_analog_encoder_repeat_enable,
    output reg o_analog_encoder_repeat_offset_shift,
    // square wave repeat output
    output reg o_square_wave_repeat_output_a,
    output reg o_square_wave_repeat_output_b,
    output reg o_square_wave_repeat_oe,
    // current output setpoint
    output reg [15:0] o_current_setpoint,
    output reg o_error
);

    // the line only makes up what the front end leaves of the pin delay
    localparam DLY = `ECIS_SQ_DELAY_CYC - `ECIS_SQ_FRONT_CYC;
    localparam FL = `ECIS_FILT_LEN;

    // ======================================================================
    // pin synchronisers and filters
    reg [3:0] sync1_reg;
    reg [3:0] sync2_reg;
    reg [3:0] filt_reg;
    reg [FL*4-1:0] hist_reg;
    reg [1:0] an_s1_reg;
    reg [1:0] an_s2_reg;
    wire [3:0] pins;
    integer k;
    assign pins = {i_command_input_two_partner, i_command_input_two,
                   i_command_input_one_partner, i_command_input_one};

    // two stages then a majority-free agreement filter
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            hist_reg <= {FL*4{1'b0}};
            filt_reg <= 4'h0;
            an_s1_reg <= 2'h0;
            an_s2_reg <= 2'h0;
        end else if (i_clock_enable) begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            hist_reg <= {hist_reg[FL*4-5:0], sync2_reg};
            an_s1_reg <= {i_first_analog_encoder_b, i_first_analog_encoder_a};
            an_s2_reg <= an_s1_reg;
            // a bit changes only after FL equal samples
            for (k = 0; k < 4; k = k + 1) begin
                if (hist_reg[k] == hist_reg[4+k] &&
                    hist_reg[4+k] == hist_reg[8+k]) begin
                    filt_reg[k] <= hist_reg[k];
                end
            end
        end
    end

    // ======================================================================
    // quadrature decoding
    reg [3:0] prev_reg;
    function [1:0] quad_step; // 01 up, 11 down, 00 none
        input [1:0] old_ab;
        input [1:0] new_ab;
        begin
            case ({old_ab, new_ab})
                4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = 2'b01;
                4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = 2'b11;
                default: quad_step = 2'b00;
            endcase
        end
    endfunction

    wire [1:0] step1 = quad_step(prev_reg[1:0], filt_reg[1:0]);
    wire [1:0] step2 = quad_step(prev_reg[3:2], filt_reg[3:2]);
    wire rise1 = filt_reg[0] & ~prev_reg[0];
    wire rise2 = filt_reg[2] & ~prev_reg[2];
    wire enc_mode = (i_input_function == `ECIS_FN_QUAD) ||
                    (i_input_function == `ECIS_FN_SINGLE);

    // counters only run in encoder modes
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prev_reg <= 4'h0;
            o_sensor_one_count <= 16'h0000;
            o_sensor_two_count <= 16'h0000;
            o_sensor_one_dir <= 1'b0;
            o_sensor_two_dir <= 1'b0;
            o_commands <= 4'h0;
        end else if (i_clock_enable) begin
            prev_reg <= filt_reg;
            o_commands <= enc_mode ? 4'h0 : filt_reg;
            if (i_input_function == `ECIS_FN_QUAD) begin
                // 90 degree pairs: 1/2 sensor one, 3/4 sensor two
                if (step1[0]) begin
                    o_sensor_one_count <= o_sensor_one_count +
                        (step1[1] ? 16'hffff : 16'h0001);
                    o_sensor_one_dir <= step1[1];
                end
                if (step2[0]) begin
                    o_sensor_two_count <= o_sensor_two_count +
                        (step2[1] ? 16'hffff : 16'h0001);
                    o_sensor_two_dir <= step2[1];
                end
            end else if (i_input_function == `ECIS_FN_SINGLE) begin
                // channel A only; partner is a static direction level
                o_sensor_one_dir <= filt_reg[1];
                o_sensor_two_dir <= filt_reg[3];
                if (rise1) begin
                    o_sensor_one_count <= o_sensor_one_count +
                        (filt_reg[1] ? 16'hffff : 16'h0001);
                end
                if (rise2) begin
                    o_sensor_two_count <= o_sensor_two_count +
                        (filt_reg[3] ? 16'hffff : 16'h0001);
                end
            end
        end
    end

    // ======================================================================
    // pair relation checks with tolerance window
    reg bad1;
    reg bad2;
    always @* begin
        bad1 = 1'b0;
        bad2 = 1'b0;
        case (i_input_function)
            `ECIS_FN_INVERSE: begin
                bad1 = (filt_reg[0] == filt_reg[1]);
                bad2 = (filt_reg[2] == filt_reg[3]);
            end
            `ECIS_FN_HOMOG: begin
                bad1 = (filt_reg[0] != filt_reg[1]);
                bad2 = (filt_reg[2] != filt_reg[3]);
            end
            `ECIS_FN_MIXED: begin
                // only the first pair is checked
                bad1 = i_mixed_pair_inverse ?
                    (filt_reg[0] == filt_reg[1]) :
                    (filt_reg[0] != filt_reg[1]);
            end
            default: begin
                bad1 = 1'b0;
            end
        endcase
    end

    reg [7:0] mis1_reg;
    reg [7:0] mis2_reg;
    reg pair_err_reg;
    // skew shorter than the window is forgiven
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mis1_reg <= 8'h00;
            mis2_reg <= 8'h00;
            pair_err_reg <= 1'b0;
        end else if (i_clock_enable) begin
            mis1_reg <= bad1 ? ((mis1_reg == 8'hff) ? mis1_reg :
                                mis1_reg + 8'h01) : 8'h00;
            mis2_reg <= bad2 ? ((mis2_reg == 8'hff) ? mis2_reg :
                                mis2_reg + 8'h01) : 8'h00;
            pair_err_reg <= (bad1 && mis1_reg >= i_mismatch_tolerance) ||
                            (bad2 && mis2_reg >= i_mismatch_tolerance);
        end
    end

    // ======================================================================
    // latched error: set wins over clear
    wire sq_src_analog_err = i_repeat_source_analog &
                             i_analog_encoder_error;
    wire err_set = pair_err_reg | i_current_loop_open |
                   i_external_error | sq_src_analog_err;
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_error <= 1'b0;
        end else if (i_clock_enable) begin
            if (err_set) begin
                o_error <= 1'b1;
            end else if (i_clear_error) begin
                o_error <= 1'b0;
            end
        end
    end

    // ======================================================================
    // analog encoder repeat controls
    wire fwd_mode = (i_operating_mode == `ECIS_OPMODE_0) ||
                    (i_operating_mode == `ECIS_OPMODE_1) ||
                    (i_operating_mode == `ECIS_OPMODE_2) ||
                    (i_operating_mode == `ECIS_OPMODE_6);
    // the analog path itself is outside; this only gates it
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_analog_encoder_repeat_enable <= 1'b0;
            o_analog_encoder_repeat_offset_shift <= 1'b0;
        end else if (i_clock_enable) begin
            o_analog_encoder_repeat_enable <= fwd_mode;
            o_analog_encoder_repeat_offset_shift <= o_error | err_set;
        end
    end

    // ======================================================================
    // square wave repeat: fixed delay line, 1:1 edges
    reg [DLY*2-1:0] dline_reg;
    reg [1:0] src;
    always @* begin
        // the squared analog pair gives one period per input period
        if (i_repeat_source_analog) begin
            src = an_s2_reg;
        end else if (i_repeat_select_sensor_two) begin
            src = filt_reg[3:2];
        end else begin
            src = filt_reg[1:0];
        end
    end

    // delay chosen so that pin to pin lands near the target
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dline_reg <= {DLY*2{1'b0}};
            o_square_wave_repeat_output_a <= 1'b0;
            o_square_wave_repeat_output_b <= 1'b0;
            o_square_wave_repeat_oe <= 1'b0;
        end else if (i_clock_enable) begin
            dline_reg <= {dline_reg[DLY*2-3:0], src};
            if (o_error || err_set) begin
                // no pulses, drivers released
                o_square_wave_repeat_output_a <= 1'b0;
                o_square_wave_repeat_output_b <= 1'b0;
                o_square_wave_repeat_oe <= 1'b0;
            end else begin
                o_square_wave_repeat_output_a <= dline_reg[DLY*2-2];
                o_square_wave_repeat_output_b <= dline_reg[DLY*2-1];
                o_square_wave_repeat_oe <= 1'b1;
            end
        end
    end

    // ======================================================================
    // current setpoint: 4 mA + 16 mA * (f - start) / (end - start)
    wire [15:0] fsel = i_analog_select_sensor_two ? i_sensor_two_freq :
                                                    i_sensor_one_freq;
    wire [15:0] span = i_analog_end_freq - i_analog_start_freq;
    wire [15:0] offs = fsel - i_analog_start_freq;
    wire [31:0] prod = offs * `ECIS_MA_SPAN;
    // divider is combinational; slow but the setpoint is not time-critical
    wire [31:0] quot = (span == 16'h0000) ? 32'h0 : prod / {16'h0, span};
    reg [15:0] sp;
    always @* begin
        if (fsel <= i_analog_start_freq) begin
            sp = `ECIS_MA_FOUR;
        end else if (fsel >= i_analog_end_freq) begin
            sp = `ECIS_MA_FOUR + `ECIS_MA_SPAN;
        end else begin
            sp = `ECIS_MA_FOUR + quot[15:0];
        end
    end

    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_current_setpoint <= `ECIS_MA_ZERO;
        end else if (i_clock_enable) begin
            o_current_setpoint <= (o_error || err_set) ?
                `ECIS_MA_ZERO : sp;
        end
    end

endmodule // ecis_splitter

// >>> verif/ecis_splitter_monitor.sv
// checker for the splitter top: error states, pair check, repeat enable
// assumes one clock domain and the design's async active low reset
`timescale 1ns/1ps
`include "ecis_defs.vh"
// ======================================================================
// checker
module ecis_splitter_monitor (
    // inputs of the top
    input wire i_clock,
    input wire i_reset_n,
    input wire i_clock_enable,
    input wire [2:0] i_input_function,
    input wire [3:0] i_operating_mode,
    input wire [7:0] i_mismatch_tolerance,
    input wire i_clear_error,
    input wire i_current_loop_open,
    input wire i_command_input_one,
    input wire i_command_input_one_partner,
    // outputs of the top
    input wire [3:0] o_commands,
    input wire o_analog_encoder_repeat_enable,
    input wire o_analog_encoder_repeat_offset_shift,
    input wire o_square_wave_repeat_oe,
    input wire [15:0] o_current_setpoint,
    input wire o_error
);
    // pair one levels equal, two-cycle tolerance, forwarding modes
    wire pair_same = i_command_input_one == i_command_input_one_partner;
    wire tol_two = i_mismatch_tolerance == 8'h02 && i_clock_enable;
    wire fwd_mode = i_operating_mode inside {4'h0, 4'h1, 4'h2, 4'h6};
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);
    // an inverse pair held equal through the filter and the tolerance
    sequence s_pair_broken;
        (i_input_function == `ECIS_FN_INVERSE && pair_same && tol_two)[*8];
    endsequence
    sequence s_quad_held;
        (i_input_function == `ECIS_FN_QUAD)[*8];
    endsequence
    a_inverse_pair_err: assert property (
        s_pair_broken |-> ##[0:4] o_error) else $error("pair not flagged");
    a_offset_on_error: assert property (
        o_error |-> o_analog_encoder_repeat_offset_shift)
        else $error("offset not shifted in error");
    a_tristate_on_error: assert property (
        o_error |-> !o_square_wave_repeat_oe)
        else $error("square drivers active in error");
    a_zero_current: assert property (
        o_error |-> o_current_setpoint == `ECIS_MA_ZERO)
        else $error("current not zero in error");
    a_loop_open_err: assert property (
        i_current_loop_open && i_clock_enable |=> o_error)
        else $error("open loop not flagged");
    a_error_latched: assert property (
        o_error && !i_clear_error |=> o_error) else $error("error dropped");
    a_repeat_enable: assert property (
        $stable(i_operating_mode)[*3] |->
        o_analog_encoder_repeat_enable == fwd_mode)
        else $error("analog repeat enable wrong for mode");
    a_quad_no_cmds: assert property (
        s_quad_held |-> o_commands == 4'h0)
        else $error("commands in encoder mode");
endmodule // ecis_splitter_monitor
bind ecis_splitter ecis_splitter_monitor u_monitor (.i_clock, .i_reset_n,
    .i_clock_enable, .i_input_function, .i_operating_mode,
    .i_mismatch_tolerance, .i_clear_error, .i_current_loop_open,
    .i_command_input_one, .i_command_input_one_partner, .o_commands,
    .o_analog_encoder_repeat_enable, .o_analog_encoder_repeat_offset_shift,
    .o_square_wave_repeat_oe, .o_current_setpoint, .o_error);

// >>> verif/ecis_htl_source.sv
// htl source model: encoders, proximity switches and plc lines
// assumes the bench sets levels and run controls after clock edges
`timescale 1ns/1ps
// ======================================================================
// htl source
module ecis_htl_source (
    // controls from the bench
    input wire i_clock,
    input wire [3:0] i_level,
    input wire i_run,
    input wire i_reverse,
    input wire i_single,
    input wire i_partner_open,
    // pins toward the splitter
    output logic [3:0] o_pins
);
    logic [5:0] step = 6'h00;
    // one quadrature step per 16 clocks, slow against the input filter
    always @(posedge i_clock) begin
        if (i_run) step <= i_reverse ? step - 6'h01 : step + 6'h01;
    end
    // a leads b by a quarter period; open partner sits at pull-down
    always @* begin
        o_pins = i_level;
        if (i_run) o_pins[0] = step[5] ^ step[4];
        if (i_run && !i_single) o_pins[1] = step[5];
        if (i_partner_open) o_pins[1] = 1'b0;
    end
endmodule // ecis_htl_source

// >>> verif/ecis_splitter_tb.sv
// bench for the splitter: pins come from the htl source model
// assumes the checker binds itself to the splitter top
`timescale 1ns/1ps
`include "ecis_defs.vh"
// ======================================================================
// bench top
module ecis_splitter_tb;
    // design inputs; tolerance and start and end frequencies stay fixed
    logic i_clock = 1'b0, i_reset_n = 1'b0, i_clock_enable = 1'b1;
    logic [2:0] i_input_function = `ECIS_FN_QUAD, err_src = 3'h0;
    logic [3:0] i_operating_mode = 4'h0, level = 4'h0;
    logic i_mixed_pair_inverse = 1'b0, i_repeat_select_sensor_two = 1'b0;
    logic i_repeat_source_analog = 1'b0, i_analog_select_sensor_two = 1'b0;
    logic [7:0] i_mismatch_tolerance = 8'h02;
    logic [15:0] i_analog_start_freq = 16'h0000;
    logic [15:0] i_analog_end_freq = 16'h03e8, i_sensor_one_freq = 16'h01f4;
    logic [15:0] i_sensor_two_freq = 16'h03e8;
    logic i_clear_error = 1'b0, run = 1'b0, reverse = 1'b0;
    logic single = 1'b0, p_open = 1'b0;
    logic [1:0] an_ab = 2'h0;
    // design outputs
    wire [3:0] pins, o_commands;
    wire [15:0] o_sensor_one_count, o_current_setpoint;
    wire o_sensor_one_dir, o_analog_encoder_repeat_enable, o_error;
    wire o_analog_encoder_repeat_offset_shift, o_square_wave_repeat_output_a;
    wire o_square_wave_repeat_oe, o_square_wave_repeat_output_b;
    wire [1:0] sq_out = {o_square_wave_repeat_output_b,
        o_square_wave_repeat_output_a};
    wire [1:0] safe = {o_square_wave_repeat_oe,
        o_analog_encoder_repeat_offset_shift};
    int failures = 0, checked = 0;
    ecis_htl_source u_src (.i_clock, .i_level(level), .i_run(run),
        .i_reverse(reverse), .i_single(single), .i_partner_open(p_open),
        .o_pins(pins));
    ecis_splitter DUT (.i_clock, .i_reset_n, .i_clock_enable,
        .i_input_function, .i_operating_mode, .i_mixed_pair_inverse,
        .i_repeat_select_sensor_two, .i_repeat_source_analog,
        .i_analog_select_sensor_two, .i_mismatch_tolerance,
        .i_analog_start_freq, .i_analog_end_freq, .i_clear_error,
        .i_command_input_one(pins[0]), .i_command_input_one_partner(pins[1]),
        .i_command_input_two(pins[2]), .i_command_input_two_partner(pins[3]),
        .i_first_analog_encoder_a(an_ab[0]),
        .i_first_analog_encoder_b(an_ab[1]),
        .i_analog_encoder_error(err_src[2]), .i_external_error(err_src[0]),
        .i_sensor_one_freq, .i_sensor_two_freq,
        .i_current_loop_open(err_src[1]), .o_commands, .o_sensor_one_count,
        .o_sensor_two_count(), .o_sensor_one_dir, .o_sensor_two_dir(),
        .o_analog_encoder_repeat_enable, .o_analog_encoder_repeat_offset_shift,
        .o_square_wave_repeat_output_a, .o_square_wave_repeat_output_b,
        .o_square_wave_repeat_oe, .o_current_setpoint, .o_error);
    // helpers: edges, compares, error wait, verdict
    always #25 i_clock = ~i_clock;
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #5;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic clear(input int n);
        i_clear_error = 1'b1;
        tick(n);
        i_clear_error = 1'b0;
    endtask
    // bounded wait, the latch needs a few filter cycles
    task automatic expect_err(input logic exp);
        repeat (60) if (o_error !== exp) tick(1);
        check(16'(o_error), 16'(exp));
    endtask
    task automatic test_done();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==================================================================
    // scenarios
    task automatic t_commands();
        i_input_function = `ECIS_FN_FOUR;
        for (int k = 1; k < 16; k += 5) begin
            level = k[3:0];
            tick(12);
            check(16'(o_commands), 16'(k[3:0]));
            check(16'(o_error), 16'h0000);
        end
        i_input_function = `ECIS_FN_QUAD;
        tick(12);
        $display("done commands");
    endtask
    // fields: function, mixed inverse flag, good levels, bad levels
    task automatic t_pairs();
        logic [11:0] tab [4];
        tab = '{{`ECIS_FN_INVERSE, 9'h067}, {`ECIS_FN_HOMOG, 9'h0c8},
            {`ECIS_FN_MIXED, 9'h041}, {`ECIS_FN_MIXED, 9'h1a0}};
        foreach (tab[k]) begin
            {i_input_function, i_mixed_pair_inverse, level} = tab[k][11:4];
            clear(20);
            level = tab[k][3:0];
            tick(1);
            level = tab[k][7:4];
            tick(20);
            check(16'(o_error), 16'h0000);
            level = tab[k][3:0];
            expect_err(1'b1);
            tick(10);
            level = tab[k][7:4];
            tick(20);
            check(16'(o_error), 16'h0001);
        end
        $display("done pairs");
    endtask
    task automatic t_square();
        i_input_function = `ECIS_FN_QUAD;
        i_repeat_select_sensor_two = 1'b1;
        level = 4'h4;
        tick(`ECIS_SQ_DELAY_CYC - 1);
        check(16'(sq_out), 16'h0002);
        tick(1);
        check(16'(sq_out), 16'h0001);
        // squared analog pair: each input level shows once on the output
        i_repeat_source_analog = 1'b1;
        an_ab = 2'h1;
        tick(20);
        check(16'(sq_out), 16'h0001);
        an_ab = 2'h2;
        tick(20);
        check(16'(sq_out), 16'h0002);
        an_ab = 2'h0;
        i_repeat_source_analog = 1'b0;
        $display("done square");
    endtask
    task automatic t_quad();
        logic [15:0] c;
        c = o_sensor_one_count;
        run = 1'b1;
        tick(130);
        check(16'(o_sensor_one_count != c), 16'h0001);
        check(16'(o_sensor_one_dir), 16'h0000);
        reverse = 1'b1;
        tick(130);
        check(16'(o_sensor_one_dir), 16'h0001);
        i_input_function = `ECIS_FN_SINGLE;
        {single, p_open} = 2'h3;
        tick(10);
        c = o_sensor_one_count;
        tick(130);
        check(16'(o_sensor_one_dir), 16'h0000);
        check(16'(16'(o_sensor_one_count - c) inside {[1:4]}), 16'h0001);
        run = 1'b0;
        $display("done quad");
    endtask
    task automatic t_setpoint();
        tick(20);
        check(o_current_setpoint, `ECIS_MA_FOUR + `ECIS_MA_SPAN / 2);
        i_analog_select_sensor_two = 1'b1;
        tick(20);
        check(o_current_setpoint, `ECIS_MA_FOUR + `ECIS_MA_SPAN);
        i_sensor_two_freq = 16'h0000;
        tick(20);
        check(o_current_setpoint, `ECIS_MA_FOUR);
        $display("done setpoint");
    endtask
    task automatic t_modes();
        logic exp_on;
        for (int m = 0; m < 10; m++) begin
            i_operating_mode = 4'(m);
            exp_on = m inside {0, 1, 2, 6};
            tick(4);
            check(16'(o_analog_encoder_repeat_enable), 16'(exp_on));
        end
        $display("done modes");
    endtask
    // set stays ahead of clear while a source is active
    task automatic t_errors();
        i_repeat_source_analog = 1'b1;
        for (int k = 0; k < 3; k++) begin
            err_src = 3'h1 << k;
            expect_err(1'b1);
            check(16'(safe), 16'h0001);
            check(o_current_setpoint, `ECIS_MA_ZERO);
            i_clear_error = 1'b1;
            tick(3);
            check(16'(o_error), 16'h0001);
            err_src = 3'h0;
            tick(3);
            check(16'(o_error), 16'h0000);
            i_clear_error = 1'b0;
        end
        // low clock enable freezes the latch; a mid-run reset clears it
        i_clock_enable = 1'b0;
        err_src = 3'h1;
        tick(5);
        check(16'(o_error), 16'h0000);
        i_clock_enable = 1'b1;
        expect_err(1'b1);
        err_src = 3'h0;
        i_reset_n = 1'b0;
        tick(2);
        check(16'({o_error, safe}), 16'h0000);
        i_reset_n = 1'b1;
        tick(2);
        check(16'({o_error, safe}), 16'h0002);
        $display("done errors");
    endtask
    // run order, then a watchdog well past about 1000 cycles of tests
    initial begin
        tick(16);
        i_reset_n = 1'b1;
        tick(12);
        t_commands();
        t_pairs();
        clear(20);
        t_square();
        t_quad();
        t_setpoint();
        t_modes();
        t_errors();
        test_done();
    end
    initial begin
        repeat (5000) @(posedge i_clock);
        failures++;
        test_done();
    end
endmodule // ecis_splitter_tb
